// [flash_host_pkg.sv]
// constants and types for the flash command host controller
//
// Contract
// [R1] erase is setup 20h then confirm D0h, both at an address in the block
// [R2] erase happens only with program supply high; host raises it via config
// [R3] after an accepted erase every read returns the status byte
// [R4] status bit 7 is machine ready; 1 idle or finished, 0 busy
// [R5] status bit 5 is erase fail flag
// [R6] B0h during erase suspends it; reads keep returning status
// [R7] suspended erase shows ready and suspend flag bit 6 both set
// [R8] while suspended, read-array and read-status commands are accepted
// [R9] D0h while suspended resumes erase, clearing suspend and ready flags
// [R10] program is 40h then address and data, latched on write enable rise
// [R11] while programming only read-status is accepted; reads give status
// [R12] status bit 4 is program fail flag
// [R13] status bit 3 is supply low flag
// [R14] status bits 2..0 are reserved; host masks them when polling
// [R15] host waits for ready before evaluating fail flags
// [R16] a non-confirm after erase setup sets both fail flags
// [R17] device samples supply once per entered sequence, not continuously
// [R18] erase or program at low supply sets the matching fail flag
// [R19] reset or supply drop during an operation halts the state machine; the device model halts only on reset going low, not on supply drop
// [R20] program verify only flags bits that failed to go 1 to 0
// [R21] boot block changes need unlock voltage, else matching fail flag
// [R22] host holds unlock voltage from before confirm until completion shows; here held only while busy, and resume is not polled
// [R23] fail flags stay set until clear-status 50h
// [R24] FFh returns the device to read-array mode
// [R25] status captured on later falling edge of output or chip enable
// [R26] supply, reset and unlock high levels are separate qualifier lines
`default_nettype none
package flash_host_pkg;
  // ************************************************************
  // registers
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam int CFG_SUPPLY_BIT = 0;
  localparam int CFG_UNLOCK_BIT = 1;
  localparam int CFG_RUN_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_RESULT_LSB = 8;
  localparam int STAT_RDATA_LSB = 16;
  // ************************************************************
  // status byte fields
  // ************************************************************
  localparam int SB_READY = 7;
  localparam int SB_SUSPEND = 6;
  localparam int SB_ERASE_FAIL = 5;
  localparam int SB_PROG_FAIL = 4;
  localparam int SB_SUPPLY_LOW = 3;
  localparam logic [7:0] SB_KEEP_MASK = 8'hF8;
  // ************************************************************
  // device command codes
  // ************************************************************
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_WE_PULSE_NS = 40;
  localparam int T_READ_NS = 150;
  localparam int T_DATA_HOLD_NS = 10;
  localparam int T_HIGH_NS = 10;
  localparam int WE_CYC = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (T_DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIGH_CYC = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [3:0] {
    OP_NONE, OP_PROGRAM, OP_ERASE, OP_SUSPEND, OP_RESUME,
    OP_READ_ARRAY, OP_READ_STATUS, OP_CLEAR_STATUS
  } op_t;
  typedef enum {TAIL_NONE, TAIL_READ, TAIL_POLL} tail_t;
endpackage : flash_host_pkg
`default_nettype wire

// [flash_bus_cycle.sv]
// one timed write or read cycle on the flash pins
`default_nettype none
module flash_bus_cycle
  import flash_host_pkg::*;
#(
  parameter int AW = 17
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic start,
  input wire logic wr,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  output logic [AW-1:0] flash_addr,
  output logic [7:0] flash_dq_o,
  input wire logic [7:0] flash_dq_i,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  typedef enum {C_IDLE, C_SET, C_STB, C_HLD, C_REC} cyc_state_t;
  cyc_state_t st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic wr_q, wr_d, done_q, done_d, dqoe_q, dqoe_d, ce_n_q, ce_n_d;
  logic oe_n_q, oe_n_d, we_n_q, we_n_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [7:0] dqo_q, dqo_d, rdata_q, rdata_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    done_d = 1'b0;
    dqoe_d = dqoe_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    addr_d = addr_q;
    dqo_d = dqo_q;
    rdata_d = rdata_q;
    case (st_q)
      C_IDLE: begin
        if (start) begin
          st_d = C_SET;
          wr_d = wr;
          addr_d = addr;
          dqo_d = wdata;
          dqoe_d = wr;
          ce_n_d = 1'b0;
        end
      end
      C_SET: begin
        st_d = C_STB;
        if (wr_q) begin
          we_n_d = 1'b0;
          cnt_d = 5'(WE_CYC - 1);
        end else begin
          oe_n_d = 1'b0;
          cnt_d = 5'(READ_CYC - 1);
        end
      end
      C_STB: begin
        if (cnt_q != 5'h00) begin
          cnt_d = cnt_q - 5'h01;
        end else begin
          st_d = C_HLD;
          cnt_d = 5'(HOLD_CYC - 1);
          // [R10] rising write enable latches
          we_n_d = 1'b1;
          // [R25] release strobe per read
          oe_n_d = 1'b1;
          if (!wr_q) begin
            rdata_d = flash_dq_i;
            ce_n_d = 1'b1;
          end
        end
      end
      C_HLD: begin
        if (cnt_q != 5'h00) begin
          cnt_d = cnt_q - 5'h01;
        end else begin
          st_d = C_REC;
          cnt_d = 5'(HIGH_CYC - 1);
          dqoe_d = 1'b0;
          ce_n_d = 1'b1;
        end
      end
      C_REC: begin
        if (cnt_q != 5'h00) begin
          cnt_d = cnt_q - 5'h01;
        end else begin
          st_d = C_IDLE;
          done_d = 1'b1;
        end
      end
      default: st_d = C_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= C_IDLE;
      cnt_q <= 5'h00;
      wr_q <= 1'b0;
      done_q <= 1'b0;
      dqoe_q <= 1'b0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      addr_q <= '0;
      dqo_q <= 8'h00;
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      done_q <= done_d;
      dqoe_q <= dqoe_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      addr_q <= addr_d;
      dqo_q <= dqo_d;
      rdata_q <= rdata_d;
    end
  end

  assign done = done_q;
  assign rdata = rdata_q;
  assign flash_addr = addr_q;
  assign flash_dq_o = dqo_q;
  assign flash_dq_oe = dqoe_q;
  assign flash_ce_n = ce_n_q;
  assign flash_oe_n = oe_n_q;
  assign flash_we_n = we_n_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_we_pulse_len: assert property ($fell(we_n_q) |-> !we_n_q[*4] ##1 we_n_q) // [R10]
    else $error("write strobe width wrong");
  a_we_data_held: assert property (!we_n_q |-> dqoe_q && !ce_n_q && oe_n_q) // [R10]
    else $error("data not driven under write strobe");
  a_data_after_rise: assert property ($rose(we_n_q) |-> dqoe_q && $stable(dqo_q)) // [R10]
    else $error("data dropped at strobe rise");
  a_read_toggle: assert property ($rose(oe_n_q) |-> oe_n_q[*2]) // [R25]
    else $error("output enable not toggled high");
endmodule : flash_bus_cycle
`default_nettype wire

// [flash_host_ctrl.sv]
// apb-controlled host that sequences flash erase, program and status commands
//
// Chosen here: the register addresses and the APB register port.
`default_nettype none
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int AW = 17
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [AW-1:0] flash_addr,
  output logic [7:0] flash_dq_o,
  input wire logic [7:0] flash_dq_i,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic reset_powerdown_n,
  output logic boot_unlock_voltage,
  output logic program_supply_high
);
  import flash_host_pkg::*;

  // ************************************************************
  // op decoding
  // ************************************************************
  function automatic logic [7:0] first_code(input op_t op);
    case (op)
      OP_PROGRAM: first_code = CMD_PROG_SETUP;
      OP_ERASE: first_code = CMD_ERASE_SETUP;
      OP_SUSPEND: first_code = CMD_SUSPEND;
      OP_RESUME: first_code = CMD_CONFIRM;
      OP_READ_STATUS: first_code = CMD_READ_STATUS;
      OP_CLEAR_STATUS: first_code = CMD_CLEAR_STATUS;
      default: first_code = CMD_READ_ARRAY;
    endcase
  endfunction : first_code

  function automatic tail_t op_tail(input op_t op);
    case (op)
      OP_PROGRAM, OP_ERASE, OP_SUSPEND: op_tail = TAIL_POLL;
      OP_READ_ARRAY, OP_READ_STATUS: op_tail = TAIL_READ;
      default: op_tail = TAIL_NONE;
    endcase
  endfunction : op_tail

  typedef enum {S_IDLE, S_FIRST, S_SECOND, S_READ, S_POLL} seq_state_t;
  seq_state_t st_q, st_d;
  op_t op_q, op_d, req_op;
  logic [AW-1:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d, result_q, result_d, rdata_q, rdata_d;
  logic [2:0] cfg_q, cfg_d;
  logic done_q, done_d, start_q, start_d, cwr_q, cwr_d;
  logic [7:0] cdata_q, cdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic cyc_done, wr_take, access, mapped, busy;
  logic [7:0] cyc_rdata;

  flash_bus_cycle #(.AW(AW)) u_cycle (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .start(start_q),
    .wr(cwr_q),
    .addr(addr_q),
    .wdata(cdata_q),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o),
    .flash_dq_i(flash_dq_i),
    .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n)
  );

  // ************************************************************
  // apb slave
  // ************************************************************
  assign busy = (st_q != S_IDLE);
  assign access = psel && penable && !pready_q;
  assign wr_take = psel && penable && pwrite && pready_q;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_ADDR) || (paddr == OFS_WDATA)
      || (paddr == OFS_CFG) || (paddr == OFS_STAT);
  assign req_op = op_t'(pwdata[3:0]);

  always_comb begin
    pready_d = access;
    pslverr_d = access && !mapped;
    prdata_d = 32'h0000_0000;
    if (access && !pwrite) begin
      case (paddr)
        OFS_CTRL: prdata_d = {28'h000_0000, op_q};
        OFS_ADDR: prdata_d = 32'(addr_q);
        OFS_WDATA: prdata_d = {24'h00_0000, wdata_q};
        OFS_CFG: prdata_d = {29'h0000_0000, cfg_q};
        OFS_STAT: begin
          prdata_d[STAT_BUSY_BIT] = busy;
          prdata_d[STAT_DONE_BIT] = done_q;
          prdata_d[STAT_RESULT_LSB +: 8] = result_q;
          prdata_d[STAT_RDATA_LSB +: 8] = rdata_q;
        end
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // command sequencer
  // ************************************************************
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    cfg_d = cfg_q;
    result_d = result_q;
    rdata_d = rdata_q;
    done_d = done_q;
    start_d = 1'b0;
    cwr_d = cwr_q;
    cdata_d = cdata_q;
    // [R22] unlock and supply frozen while busy
    if (wr_take && !busy) begin
      case (paddr)
        OFS_ADDR: addr_d = pwdata[AW-1:0];
        OFS_WDATA: wdata_d = pwdata[7:0];
        OFS_CFG: cfg_d = pwdata[2:0];
        default: ;
      endcase
      if (paddr == OFS_CTRL && req_op != OP_NONE && pwdata[3:0] <= 4'h7) begin
        // [R1] [R8] [R10] [R24] setup code first
        op_d = req_op;
        st_d = S_FIRST;
        start_d = 1'b1;
        cwr_d = 1'b1;
        cdata_d = first_code(req_op);
        done_d = 1'b0;
      end
    end
    case (st_q)
      S_FIRST: begin
        if (cyc_done) begin
          start_d = 1'b1;
          if (op_q == OP_PROGRAM || op_q == OP_ERASE) begin
            st_d = S_SECOND;
            // [R1] [R10] confirm or data, same address
            cdata_d = (op_q == OP_PROGRAM) ? wdata_q : CMD_CONFIRM;
          end else if (op_tail(op_q) == TAIL_READ) begin
            st_d = S_READ;
            cwr_d = 1'b0;
          end else if (op_tail(op_q) == TAIL_POLL) begin
            st_d = S_POLL;
            cwr_d = 1'b0;
          end else begin
            start_d = 1'b0;
            st_d = S_IDLE;
            done_d = 1'b1;
          end
        end
      end
      S_SECOND: begin
        if (cyc_done) begin
          st_d = S_POLL;
          start_d = 1'b1;
          cwr_d = 1'b0;
        end
      end
      S_READ: begin
        if (cyc_done) begin
          rdata_d = cyc_rdata;
          if (op_q == OP_READ_STATUS) begin
            // [R14] reserved bits masked
            result_d = cyc_rdata & SB_KEEP_MASK;
          end
          st_d = S_IDLE;
          done_d = 1'b1;
        end
      end
      S_POLL: begin
        if (cyc_done) begin
          // [R15] flags kept only once ready
          if (cyc_rdata[SB_READY]) begin
            result_d = cyc_rdata & SB_KEEP_MASK;
            st_d = S_IDLE;
            done_d = 1'b1;
          end else begin
            // [R25] fresh read for each poll
            start_d = 1'b1;
          end
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= S_IDLE;
      op_q <= OP_NONE;
      addr_q <= '0;
      wdata_q <= 8'h00;
      cfg_q <= CFG_RESET;
      result_q <= 8'h00;
      rdata_q <= 8'h00;
      done_q <= 1'b0;
      start_q <= 1'b0;
      cwr_q <= 1'b0;
      cdata_q <= 8'h00;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      st_q <= st_d;
      op_q <= op_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      cfg_q <= cfg_d;
      result_q <= result_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
      start_q <= start_d;
      cwr_q <= cwr_d;
      cdata_q <= cdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  // [R2] [R26] qualifier lines from config
  assign program_supply_high = cfg_q[CFG_SUPPLY_BIT];
  assign boot_unlock_voltage = cfg_q[CFG_UNLOCK_BIT];
  assign reset_powerdown_n = cfg_q[CFG_RUN_BIT];

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_erase_setup_code: assert property (start_q && st_q == S_FIRST && op_q == OP_ERASE
      |-> cwr_q && cdata_q == 8'h20) // [R1]
    else $error("erase setup code wrong");
  a_erase_confirm: assert property (start_q && st_q == S_SECOND && op_q == OP_ERASE
      |-> cwr_q && cdata_q == 8'hD0 && $stable(addr_q)) // [R1]
    else $error("erase confirm wrong");
  a_prog_setup_code: assert property (start_q && st_q == S_FIRST && op_q == OP_PROGRAM
      |-> cdata_q == 8'h40 ##1 !start_q) // [R10]
    else $error("program setup code wrong");
  a_rsv_masked: assert property (result_q[2:0] == 3'h0) // [R14]
    else $error("reserved status bits kept");
  a_fail_after_ready: assert property ($rose(done_q) && op_tail(op_q) == TAIL_POLL
      |-> result_q[SB_READY]) // [R15]
    else $error("result taken before ready");
  a_unlock_held: assert property (busy |=> $stable(cfg_q)) // [R22]
    else $error("qualifiers moved during operation");
  a_apb_one_wait: assert property (psel && !penable ##1 psel && penable
      |-> !pready_q ##1 pready_q) // apb timing, chosen here
    else $error("apb answer timing wrong");
  cv_program: cover property ($rose(done_q) && op_q == OP_PROGRAM);
  cv_erase: cover property ($rose(done_q) && op_q == OP_ERASE);
  cv_suspend: cover property ($rose(done_q) && op_q == OP_SUSPEND && result_q[SB_SUSPEND]);
  cv_poll_again: cover property (st_q == S_POLL && cyc_done && !cyc_rdata[SB_READY]);
endmodule : flash_host_ctrl
`default_nettype wire

// [flash_dev_model.sv]
// behavioural flash device answering the host's bus cycles
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int AW = 17,
  parameter int BUSY = 20,
  parameter int BLK = 4096,
  parameter int BOOT_BASE = 'h1C000
) (
  input wire logic core_clk,
  input wire logic [AW-1:0] flash_addr,
  input wire logic [7:0] flash_dq_o,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic reset_powerdown_n,
  input wire logic boot_unlock_voltage,
  input wire logic program_supply_high,
  output logic [7:0] flash_dq_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] sb;
  logic [7:0] rd_q;
  logic [7:0] last_q;
  logic [1:0] pend;
  logic stat_mode;
  logic susp;
  logic erasing;
  logic rd_n;
  int busy_cnt;
  int base;
  assign rd_n = flash_ce_n | flash_oe_n;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    // reserved bits nonzero so the host must mask them
    sb = 8'h85;
    {pend, stat_mode, susp, erasing, busy_cnt} = '0;
    rd_q = 8'h00;
    last_q = 8'h00;
  end
  function automatic logic locked(input logic [AW-1:0] a);
    return (int'(a) >= BOOT_BASE) && !boot_unlock_voltage;
  endfunction : locked
  task automatic begin_op(input logic er);
    busy_cnt = BUSY;
    sb[7] = 1'b0;
    erasing = er;
  endtask : begin_op
  // ************************************************************
  // command decode on write enable rise
  // ************************************************************
  // latch and sample qualifiers
  always @(posedge flash_we_n) begin
    if (!flash_ce_n && reset_powerdown_n) begin
      if (busy_cnt > 0 && !susp) begin
        // only status or suspend while busy
        if (flash_dq_o == CMD_READ_STATUS) stat_mode = 1'b1;
        else if (erasing && flash_dq_o == CMD_SUSPEND) begin
          susp = 1'b1;
          sb[7:6] = 2'b11;
        end
      end else if (pend == 2'd1) begin
        pend = 2'd0;
        stat_mode = 1'b1;
        if (!program_supply_high) sb[4:3] = 2'b11;
        else if (locked(flash_addr)) sb[4] = 1'b1;
        else begin
          mem[flash_addr] = mem[flash_addr] & flash_dq_o;
          begin_op(1'b0);
        end
      end else if (pend == 2'd2) begin
        pend = 2'd0;
        stat_mode = 1'b1;
        base = int'(flash_addr) / BLK * BLK;
        if (flash_dq_o != CMD_CONFIRM) sb[5:4] = 2'b11;
        else if (!program_supply_high) sb[5:3] = 3'b101;
        else if (locked(flash_addr)) sb[5] = 1'b1;
        else begin
          for (int i = 0; i < BLK; i++) mem[base + i] = 8'hFF;
          begin_op(1'b1);
        end
      end else begin
        case (flash_dq_o)
          CMD_PROG_SETUP: pend = 2'd1;
          CMD_ERASE_SETUP: pend = 2'd2;
          CMD_READ_STATUS: stat_mode = 1'b1;
          CMD_CLEAR_STATUS: sb[5:3] = 3'b000;
          CMD_READ_ARRAY: stat_mode = 1'b0;
          CMD_CONFIRM: if (susp) begin
            susp = 1'b0;
            sb[7:6] = 2'b00;
            stat_mode = 1'b1;
          end
          default: ;
        endcase
      end
    end
  end
  always @(posedge core_clk) begin
    if (busy_cnt > 0 && !susp) begin
      if (busy_cnt == 1) sb[7] = 1'b1;
      busy_cnt = busy_cnt - 1;
    end
  end
  always @(negedge reset_powerdown_n) begin
    {busy_cnt, susp, pend, stat_mode} = '0;
    sb[7:6] = 2'b10;
  end
  // latch on the later falling edge
  always @(negedge rd_n) rd_q = stat_mode ? sb : mem[flash_addr];
  always @(posedge rd_n) last_q = rd_q;
  // released bus shows a changed pattern
  assign flash_dq_i = rd_n ? ~last_q : rd_q;
endmodule : flash_dev_model
`default_nettype wire

// [flash_host_ctrl_bench.sv]
// self-checking bench for the flash command host controller
`default_nettype none
module flash_host_ctrl_bench;
  import flash_host_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [2:0] cfg;
    logic [3:0] op;
    logic [16:0] addr;
    logic [7:0] wd;
    logic [1:0] chk;
    logic [7:0] exp;
  } row_t;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, dq_oe;
  logic ce_n, oe_n, we_n, rpd_n, unlock, supply;
  logic [7:0] paddr, dq_o, dq_i;
  logic [31:0] pwdata, prdata, r;
  logic [16:0] faddr;
  logic e;
  int bad_count, compares, cyc;
  row_t rows [16] = '{
    '{5, 1, 'h100, 'h3C, 1, 'h80}, '{5, 5, 'h100, 0, 2, 'h3C},
    '{5, 1, 'h100, 'hF0, 1, 'h80}, '{5, 5, 'h100, 0, 2, 'h30},
    '{4, 1, 'h200, 0, 1, 'h98}, '{5, 6, 0, 0, 1, 'h98},
    '{5, 7, 0, 0, 0, 0}, '{5, 6, 0, 0, 1, 'h80},
    '{5, 2, 'h1C010, 0, 1, 'hA0}, '{5, 7, 0, 0, 0, 0},
    '{7, 2, 'h1C010, 0, 1, 'h80}, '{5, 2, 'h50, 0, 1, 'h80},
    '{5, 5, 'h100, 0, 2, 'hFF}, '{4, 2, 'h50, 0, 1, 'hA8},
    '{5, 3, 0, 0, 1, 'hA8}, '{5, 4, 0, 0, 0, 0}};
  flash_host_ctrl #(.AW(17)) flash_host_ctrl_i (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(faddr),
    .flash_dq_o(dq_o), .flash_dq_i(dq_i), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .reset_powerdown_n(rpd_n),
    .boot_unlock_voltage(unlock), .program_supply_high(supply));
  // long busy time leaves room to suspend an erase after a host reset
  flash_dev_model #(.AW(17), .BUSY(100)) flash_dev_model_i (.core_clk(core_clk),
    .flash_addr(faddr),
    .flash_dq_o(dq_o), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .reset_powerdown_n(rpd_n), .boot_unlock_voltage(unlock), .program_supply_high(supply),
    .flash_dq_i(dq_i));
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic start_op(input row_t t);
    apb(1'b1, OFS_CFG, 32'(t.cfg));
    apb(1'b1, OFS_ADDR, 32'(t.addr));
    apb(1'b1, OFS_WDATA, 32'(t.wd));
    apb(1'b1, OFS_CTRL, 32'(t.op));
  endtask : start_op
  task automatic wait_done();
    do apb(1'b0, OFS_STAT, 32'h0); while (r[1:0] !== 2'b10);
  endtask : wait_done
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    repeat (3) @(posedge core_clk);
    check({ce_n, oe_n, we_n, dq_oe, pready, rpd_n, unlock, supply}, 33'hE4);
    rst <= 1'b0;
    apb(1'b0, OFS_CFG, 32'h0);
    check(r, 33'h4);
    foreach (rows[i]) begin
      start_op(rows[i]);
      wait_done();
      if (rows[i].chk == 2'd1) check(r[15:8], rows[i].exp);
      if (rows[i].chk == 2'd2) check(r[23:16], rows[i].exp);
    end
    // writes while busy are dropped, unlock never raised
    start_op(row_t'{5, 1, 'h300, 'h55, 0, 0});
    apb(1'b1, OFS_CFG, 32'h7);
    wait_done();
    check(r[15:8], 33'hA8);
    apb(1'b0, OFS_CFG, 32'h0);
    check({unlock, r}, 33'h5);
    // op code zero starts nothing
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b0, OFS_STAT, 32'h0);
    check(r[1:0], 33'h2);
    apb(1'b0, 8'h14, 32'h0);
    check({e, r}, 33'h1_0000_0000);
    // host reset in mid-erase, then suspend, read elsewhere, resume
    start_op(row_t'{5, 2, 'h2000, 0, 0, 0});
    repeat (30) @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check({ce_n, oe_n, we_n, dq_oe, pready, rpd_n, unlock, supply}, 33'hE4);
    apb(1'b1, OFS_CTRL, 32'h3);
    wait_done();
    check(r[15:8], 33'hE8);
    start_op(row_t'{4, 5, 'h300, 0, 0, 0});
    wait_done();
    check(r[23:16], 33'h55);
    start_op(row_t'{4, 4, 0, 0, 0, 0});
    wait_done();
    start_op(row_t'{4, 6, 0, 0, 0, 0});
    wait_done();
    check(r[15:8], 33'h28);
    apb(1'b1, OFS_CFG, 32'h0);
    apb(1'b0, OFS_CFG, 32'h0);
    check(rpd_n, 33'h0);
    stop_test();
  end
endmodule : flash_host_ctrl_bench
`default_nettype wire
